// ===== lpfg_core.sv
/*
  Register core of the 16-channel LED PWM controller: register file, shadow duty storage,
  eight-frame memory, frame sequencer, audio frame picker and port logic of the upper channels.
  Assumes a byte write/read port driven by an I2C slave, an ADC sample presented as a byte,
  and analog sinks that take the current scale, gain and on/off/pwm levels per channel.
*/
// Contract
// - current scale code maps 1.0,0.75,0.5,0.25,2.0,1.75,1.5,1.25 times reference
// - auto level control active with its bit 0, inactive with 1
// - audio gain 0 dB to 21 dB in 3 dB steps by code
// - channel-function bit 0 is LED, 1 is port; resets to zero
// - port channels ignore lighting current and gain settings
// - direction bit 0 output, 1 input for port channels
// - port output drives low for level 0, high for level 1
// - mask bit 0 enables change alerts, 1 disables them
// - input-state register captures port pins, bit 7 channel 16, readable
// - change alert held low until the input-state register is read
// - audio sample rate is 100 kHz divided by the divisor register
// - duty value gives current of maximum times value over 256; here the pwm output only flags a nonzero duty
// - duty registers at 10h to 1Fh, lowest address is channel 16
// - eight 18-byte frames from 20h to AFh, two on bytes then sixteen duty
// - duty writes go to shadow, commit on writing zero at B0h
// - frame hold code: 4.87 ms, 9.5 ms, then doubling to 608 ms
// - first-frame code n starts play at frame n+1
// - playback runs to frame 8, wraps to frame 1, repeats
// - mode 00 drives all channels from duty registers directly
// - mode 01 plays the stored frames automatically in sequence
// - audio mode picks frame 1 for smallest sample, frame 8 for largest
// - interrupt-enabled input change pulls the change alert low
`timescale 1ns/1ps
module lpfg_core
  import lpfg_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire lpfg_req_t req_in,
  input wire logic [7:0] adc_sample_in,
  input wire logic [7:0] port_pin_in,
  output logic [7:0] rd_data_out,
  output lpfg_led_t led_out,
  output logic [2:0] frame_index_out,
  output logic sample_strobe_out,
  output logic shutdown_out,
  output logic audio_modulate_out,
  output logic [7:0] port_out,
  output logic [7:0] port_oe_n_out,
  output logic change_alert_n_out
);
  // ==========================================================
  // register file
  logic [7:0] cfg;
  logic [7:0] ch_on_hi;
  logic [7:0] ch_on_lo;
  logic [7:0] effect;
  logic [7:0] channel_function;
  logic [7:0] pin_direction;
  logic [7:0] pin_drive_level;
  logic [7:0] change_alert_mask;
  logic [7:0] sampler_divisor;
  logic [7:0] frame_interval;
  logic [7:0] frame_first;
  logic [7:0] duty_shadow [CH_COUNT];
  logic [7:0] duty_active [CH_COUNT];
  logic [7:0] frame_memory [MEM_BYTES];
  lpfg_mode_t mode;

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // lowest duty address belongs to channel 16, index 15
  function automatic logic [3:0] duty_slot(input logic [7:0] a);
    logic [7:0] d;
    d = a - OFF_DUTY_FIRST;
    duty_slot = 4'hf - d[3:0];
  endfunction

  logic wr_hit;
  assign wr_hit = req_in.wr;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg <= RST_CONFIG;
      ch_on_hi <= RST_CH_ON;
      ch_on_lo <= RST_CH_ON;
      effect <= RST_ZERO;
      channel_function <= RST_ZERO;
      pin_direction <= RST_ZERO;
      pin_drive_level <= RST_ZERO;
      change_alert_mask <= RST_ZERO;
      sampler_divisor <= RST_ZERO;
      frame_interval <= RST_ZERO;
      frame_first <= RST_ZERO;
    end else if (wr_hit) begin
      case (req_in.addr)
        OFF_CONFIG: cfg <= req_in.data;
        OFF_CH_ON_HI: ch_on_hi <= req_in.data;
        OFF_CH_ON_LO: ch_on_lo <= req_in.data;
        OFF_EFFECT: effect <= req_in.data;
        OFF_CHANNEL_FUNCTION: channel_function <= req_in.data;
        OFF_PIN_DIRECTION: pin_direction <= req_in.data;
        OFF_PIN_DRIVE_LEVEL: pin_drive_level <= req_in.data;
        OFF_CHANGE_ALERT_MASK: change_alert_mask <= req_in.data;
        OFF_SAMPLER_DIVISOR: sampler_divisor <= req_in.data;
        OFF_FRAME_INTERVAL: frame_interval <= req_in.data;
        OFF_FRAME_FIRST: frame_first <= req_in.data;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // shadow and active duty storage
  logic commit;
  assign commit = wr_hit && (req_in.addr == OFF_DUTY_COMMIT) && (req_in.data == COMMIT_CODE);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < CH_COUNT; i++) begin
        duty_shadow[i] <= RST_ZERO;
        duty_active[i] <= RST_ZERO;
      end
    end else begin
      if (wr_hit && in_range(req_in.addr, OFF_DUTY_FIRST, OFF_DUTY_LAST)) begin
        duty_shadow[duty_slot(req_in.addr)] <= req_in.data;
      end
      if (commit) begin
        // a write in the commit cycle lands in shadow only; next commit carries it
        for (int i = 0; i < CH_COUNT; i++) begin
          duty_active[i] <= duty_shadow[i];
        end
      end
    end
  end

  // ==========================================================
  // frame memory, no reset: contents undefined until written
  always_ff @(posedge clk_in) begin
    if (wr_hit && in_range(req_in.addr, OFF_FRAME_FIRST_BYTE, OFF_FRAME_LAST_BYTE)) begin
      frame_memory[8'(req_in.addr - OFF_FRAME_FIRST_BYTE)] <= req_in.data;
    end
  end

  // ==========================================================
  // mode decode
  always_comb begin
    case (cfg[CFG_MODE_LSB +: 2])
      2'b01: mode = LPFG_MODE_AUTO;
      2'b10: mode = LPFG_MODE_AUDIO;
      default: mode = LPFG_MODE_DUTY;
    endcase
  end

  // ==========================================================
  // auto frame sequencer
  logic [2:0] hold_code;
  logic [31:0] hold_cycles;
  logic [31:0] hold_count;
  logic [2:0] play_frame;
  logic auto_mode_d;
  assign hold_code = frame_interval[HOLD_LSB +: 3];

  always_comb begin
    if (hold_code == 3'h0) begin
      hold_cycles = HOLD0_CYC;
    end else begin
      hold_cycles = HOLD1_CYC << (hold_code - 3'h1);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_count <= 32'h0;
      play_frame <= 3'h0;
      auto_mode_d <= 1'b0;
    end else begin
      auto_mode_d <= (mode == LPFG_MODE_AUTO);
      if (mode != LPFG_MODE_AUTO) begin
        hold_count <= 32'h0;
        play_frame <= frame_first[FIRST_LSB +: 3];
      end else if (!auto_mode_d) begin
        hold_count <= 32'h0;
        play_frame <= frame_first[FIRST_LSB +: 3];
      end else if (hold_count + 32'h1 >= hold_cycles) begin
        hold_count <= 32'h0;
        play_frame <= play_frame + 3'h1;
      end else begin
        hold_count <= hold_count + 32'h1;
      end
    end
  end

  // ==========================================================
  // audio sampler: one sample per divisor ticks of 100 kHz
  logic [7:0] base_count;
  logic [7:0] div_count;
  logic [7:0] sample;
  logic base_tick;
  assign base_tick = (base_count == 8'(SAMPLE_BASE_CYC - 1));

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      base_count <= 8'h0;
      div_count <= 8'h0;
      sample <= 8'h0;
      sample_strobe_out <= 1'b0;
    end else begin
      sample_strobe_out <= 1'b0;
      base_count <= base_tick ? 8'h0 : base_count + 8'h1;
      // divisor zero stops sampling
      if (mode == LPFG_MODE_AUDIO && base_tick && sampler_divisor != 8'h0) begin
        if (div_count + 8'h1 >= sampler_divisor) begin
          div_count <= 8'h0;
          sample <= adc_sample_in;
          sample_strobe_out <= 1'b1;
        end else begin
          div_count <= div_count + 8'h1;
        end
      end
    end
  end

  // ==========================================================
  // frame selection and channel outputs
  logic [2:0] shown_frame;
  logic [7:0] frame_base;
  always_comb begin
    case (mode)
      LPFG_MODE_AUTO: shown_frame = play_frame;
      LPFG_MODE_AUDIO: shown_frame = sample[7:5];
      default: shown_frame = 3'h0;
    endcase
    frame_base = 8'(shown_frame * FRAME_BYTES);
  end

  logic [7:0] level [CH_COUNT];
  logic [15:0] on_bits;
  always_comb begin
    on_bits = {ch_on_hi, ch_on_lo};
    if (mode != LPFG_MODE_DUTY) begin
      on_bits = {frame_memory[frame_base], frame_memory[8'(frame_base + 8'h1)]};
    end
  end

  genvar g;
  generate
    for (g = 0; g < CH_COUNT; g++) begin : g_ch
      // frame duty bytes follow the same high-channel-first order as the duty registers
      assign level[g] = (mode == LPFG_MODE_DUTY) ? duty_active[g]
                        : frame_memory[8'(frame_base + 8'(17 - g))];
    end
  endgenerate

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      led_out <= '0;
      frame_index_out <= 3'h0;
      shutdown_out <= 1'b1;
      audio_modulate_out <= 1'b0;
    end else begin
      // pwm bit is high for any nonzero duty; the duty value itself does not reach the sinks
      for (int i = 0; i < CH_COUNT; i++) begin
        led_out.pwm[i] <= (level[i] != 8'h0);
      end
      led_out.enable <= on_bits & ~{channel_function, 8'h00};
      led_out.current_scale <= effect[EFF_CS_LSB +: 3];
      led_out.input_gain_select <= effect[EFF_GAIN_LSB +: 3];
      led_out.auto_level_enable <= ~effect[EFF_ALC_BIT];
      frame_index_out <= shown_frame;
      shutdown_out <= cfg[7];
      audio_modulate_out <= cfg[4];
    end
  end

  // ==========================================================
  // pwm counter: active high while counter below duty
  logic [7:0] pwm_count;
  logic [15:0] pwm_level;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pwm_count <= 8'h0;
      pwm_level <= 16'h0;
    end else begin
      pwm_count <= pwm_count + 8'h1;
      for (int i = 0; i < CH_COUNT; i++) begin
        pwm_level[i] <= (pwm_count < level[i]);
      end
    end
  end

  // ==========================================================
  // upper-channel port logic
  logic [7:0] sync_a;
  logic [7:0] sync_b;
  logic [7:0] pin_input_state;
  logic [7:0] watched;
  logic alert;
  logic state_read;
  logic change;
  assign watched = channel_function & pin_direction & ~change_alert_mask;
  assign change = |((sync_b ^ pin_input_state) & watched);
  assign state_read = req_in.rd && (req_in.addr == OFF_PIN_INPUT_STATE);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_a <= 8'h0;
      sync_b <= 8'h0;
      pin_input_state <= 8'h0;
    end else begin
      sync_a <= port_pin_in;
      sync_b <= sync_a;
      pin_input_state <= sync_b;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      alert <= 1'b0;
    end else if (change) begin
      alert <= 1'b1;
    end else if (state_read) begin
      alert <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      port_out <= 8'h0;
      port_oe_n_out <= 8'hff;
      rd_data_out <= 8'h0;
    end else begin
      port_out <= pin_drive_level;
      port_oe_n_out <= ~(channel_function & ~pin_direction);
      if (req_in.rd) begin
        rd_data_out <= (req_in.addr == OFF_PIN_INPUT_STATE) ? pin_input_state : 8'h00;
      end
    end
  end

  assign change_alert_n_out = ~alert;
endmodule

// ===== lpfg_pkg.sv
/*
  Package for the LED PWM frame and port controller core: register offsets, field positions,
  reset values, timing counts and the carrier structs.
  Assumes a 25 MHz core clock and a byte-wide register write/read port fed by an I2C slave.
*/
package lpfg_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // register offsets
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_CH_ON_HI = 8'h01;
  localparam logic [7:0] OFF_CH_ON_LO = 8'h02;
  localparam logic [7:0] OFF_EFFECT = 8'h03;
  localparam logic [7:0] OFF_CHANNEL_FUNCTION = 8'h04;
  localparam logic [7:0] OFF_PIN_DIRECTION = 8'h05;
  localparam logic [7:0] OFF_PIN_DRIVE_LEVEL = 8'h06;
  localparam logic [7:0] OFF_CHANGE_ALERT_MASK = 8'h07;
  localparam logic [7:0] OFF_PIN_INPUT_STATE = 8'h08;
  localparam logic [7:0] OFF_SAMPLER_DIVISOR = 8'h09;
  localparam logic [7:0] OFF_DUTY_FIRST = 8'h10;
  localparam logic [7:0] OFF_DUTY_LAST = 8'h1f;
  localparam logic [7:0] OFF_FRAME_FIRST_BYTE = 8'h20;
  localparam logic [7:0] OFF_FRAME_LAST_BYTE = 8'haf;
  localparam logic [7:0] OFF_DUTY_COMMIT = 8'hb0;
  localparam logic [7:0] OFF_FRAME_INTERVAL = 8'hb6;
  localparam logic [7:0] OFF_FRAME_FIRST = 8'hb7;
  localparam logic [7:0] COMMIT_CODE = 8'h00;
  localparam int unsigned FRAME_BYTES = 18;
  localparam int unsigned FRAME_COUNT = 8;
  localparam int unsigned MEM_BYTES = FRAME_BYTES * FRAME_COUNT;
  localparam int unsigned CH_COUNT = 16;
  // field positions
  localparam int unsigned CFG_MODE_LSB = 5;
  localparam int unsigned EFF_CS_LSB = 4;
  localparam int unsigned EFF_ALC_BIT = 3;
  localparam int unsigned EFF_GAIN_LSB = 0;
  localparam int unsigned HOLD_LSB = 5;
  localparam int unsigned FIRST_LSB = 5;
  // reset values
  localparam logic [7:0] RST_CONFIG = 8'h80;
  localparam logic [7:0] RST_CH_ON = 8'hff;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // timing: base frame hold 4.87 ms for code 0; code k>0 holds 9.5 ms * 2^(k-1)
  localparam int unsigned HOLD0_US = 4870;
  localparam int unsigned HOLD1_US = 9500;
  localparam int unsigned HOLD0_CYC = HOLD0_US * (CLK_HZ / 1000000);
  localparam int unsigned HOLD1_CYC = HOLD1_US * (CLK_HZ / 1000000);
  localparam int unsigned SAMPLE_BASE_HZ = 100000;
  localparam int unsigned SAMPLE_BASE_CYC = CLK_HZ / SAMPLE_BASE_HZ;

  typedef enum logic [2:0] {
    LPFG_MODE_DUTY = 3'b001,
    LPFG_MODE_AUTO = 3'b010,
    LPFG_MODE_AUDIO = 3'b100
  } lpfg_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } lpfg_req_t;

  typedef struct packed {
    logic [15:0] pwm;
    logic [15:0] enable;
    logic [2:0] current_scale;
    logic [2:0] input_gain_select;
    logic auto_level_enable;
  } lpfg_led_t;
endpackage

// ===== lpfg_core_properties.sv
/* port checker for lpfg_core.
   assumes it sees only the core's ports, one clock domain. */
`timescale 1ns/1ps
module lpfg_core_properties
  import lpfg_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire lpfg_req_t req_in,
  input wire logic [7:0] port_pin_in,
  input wire logic [7:0] rd_data_out,
  input wire logic [7:0] port_out,
  input wire logic [7:0] port_oe_n_out,
  input wire logic sample_strobe_out,
  input wire logic change_alert_n_out
);
  // ====================
  // request decodes
  logic rd_state;
  logic wr_port;
  logic wr_lvl;
  assign rd_state = req_in.rd && req_in.addr == OFF_PIN_INPUT_STATE;
  assign wr_port = req_in.wr && (req_in.addr == OFF_CHANNEL_FUNCTION ||
                                 req_in.addr == OFF_PIN_DIRECTION);
  assign wr_lvl = req_in.wr && req_in.addr == OFF_PIN_DRIVE_LEVEL;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // ====================
  // assertions
  a_alert_release: assert property ($rose(change_alert_n_out) |-> $past(rd_state))
    else $error("alert released without state read");
  a_alert_hold: assert property (!change_alert_n_out && !rd_state |=> !change_alert_n_out)
    else $error("alert dropped early");
  // two sync stages plus the compare stage put the pin change four edges back
  a_alert_pin: assert property ($fell(change_alert_n_out) |->
    $past(port_pin_in, 3) != $past(port_pin_in, 4))
    else $error("alert without pin change");
  a_oe_cause: assert property ($changed(port_oe_n_out) |->
    $past(wr_port) || $past(wr_port, 2))
    else $error("oe changed without config write");
  a_level_cause: assert property ($changed(port_out) |->
    $past(wr_lvl) || $past(wr_lvl, 2))
    else $error("port level changed without write");
  a_rd_other: assert property (req_in.rd && !rd_state |=> rd_data_out == 8'h00)
    else $error("read of other address not zero");
  a_rd_stands: assert property ($changed(rd_data_out) |-> $past(req_in.rd))
    else $error("read data changed without read");
  a_strobe_gap: assert property (sample_strobe_out |=> !sample_strobe_out [*8])
    else $error("sample strobes too close");
  c_alert: cover property ($fell(change_alert_n_out));
  c_strobe: cover property (sample_strobe_out);
  c_state: cover property (rd_state ##1 rd_data_out != 8'h00);
endmodule

bind lpfg_core lpfg_core_properties u_props (
  .clk_in(clk_in),
  .reset_n_in(reset_n_in),
  .req_in(req_in),
  .port_pin_in(port_pin_in),
  .rd_data_out(rd_data_out),
  .port_out(port_out),
  .port_oe_n_out(port_oe_n_out),
  .sample_strobe_out(sample_strobe_out),
  .change_alert_n_out(change_alert_n_out)
);

// ===== lpfg_host_model.sv
/* host model: one-cycle register writes and reads.
   assumes the core takes requests on the rising edge. */
`timescale 1ns/1ps
module lpfg_host_model
  import lpfg_pkg::*;
(
  input wire logic clk_in,
  input wire logic [7:0] rd_data_in,
  output lpfg_req_t req_out
);
  // ====================
  // bus cycles
  initial req_out = '0;
  task automatic cycle(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req_out <= '{wr: w, rd: !w, addr: a, data: d};
    @(posedge clk_in);
    // released lines show junk, not the last value
    req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    cycle(1'b1, a, d);
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    cycle(1'b0, a, 8'h00);
    @(negedge clk_in);
    d = rd_data_in;
  endtask
  task automatic commit();
    write_reg(OFF_DUTY_COMMIT, COMMIT_CODE);
  endtask
endmodule

// ===== led_pwm_frame_gpio_ctrl_test.sv
/* self-checking bench for lpfg_core with the host model.
   assumes the 25 MHz clock and the package offsets. */
`timescale 1ns/1ps
module led_pwm_frame_gpio_ctrl_test
  import lpfg_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] adc = 8'h00;
  logic [7:0] pins = 8'h00;
  lpfg_req_t req;
  logic [7:0] rd_data;
  logic [7:0] port_lvl;
  logic [7:0] port_oe_n;
  lpfg_led_t led;
  logic [2:0] frame;
  logic strobe;
  logic alert_n;
  logic shdn;
  int mismatches = 0;
  int cmp_count = 0;
  int seed = 23211;
  always #20 clk = ~clk;
  lpfg_core dut (.clk_in(clk), .reset_n_in(reset_n), .req_in(req),
    .adc_sample_in(adc), .port_pin_in(pins), .rd_data_out(rd_data),
    .led_out(led), .frame_index_out(frame), .sample_strobe_out(strobe),
    .shutdown_out(shdn), .audio_modulate_out(), .port_out(port_lvl),
    .port_oe_n_out(port_oe_n), .change_alert_n_out(alert_n));
  lpfg_host_model host (.clk_in(clk), .rd_data_in(rd_data), .req_out(req));
  // ====================
  // helpers
  function automatic logic [7:0] exp_oe_n(input logic [7:0] fn, input logic [7:0] dir);
    return ~(fn & ~dir);
  endfunction
  function automatic logic [15:0] exp_gap(input logic [7:0] div);
    return 16'(SAMPLE_BASE_CYC * div);
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask
  task automatic wait_strobe(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (strobe !== 1'b1 && n < 2000);
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ====================
  // scenarios
  initial begin
    logic [7:0] r;
    logic [7:0] f;
    logic [7:0] d;
    logic [7:0] v;
    logic [2:0] g;
    int gap;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    check("oe_n reset", port_oe_n, 8'hff);
    check("alert reset", alert_n, 1'b1);
    check("shutdown reset", shdn, 1'b1);
    for (int i = 0; i < 8; i++) begin
      v = 8'(i);
      g = ~v[2:0];
      host.write_reg(OFF_EFFECT, {1'b0, v[2:0], v[0], g});
      settle();
      check("scale", led.current_scale, v[2:0]);
      check("alc", led.auto_level_enable, !v[0]);
      check("gain", led.input_gain_select, g);
    end
    host.write_reg(OFF_CONFIG, 8'h00);
    settle();
    check("shutdown off", shdn, 1'b0);
    d = $random(seed) | 8'h01;
    host.write_reg(OFF_DUTY_LAST, d);
    host.write_reg(OFF_DUTY_FIRST, d);
    host.write_reg(OFF_DUTY_COMMIT, 8'h01);
    settle();
    check("pwm shadow", led.pwm, 16'h0000);
    host.commit();
    settle();
    check("pwm commit", led.pwm, 16'h8001);
    for (int i = 0; i < 4; i++) begin
      f = $random(seed);
      r = $random(seed);
      v = $random(seed);
      host.write_reg(OFF_CHANNEL_FUNCTION, f);
      host.write_reg(OFF_PIN_DIRECTION, r);
      host.write_reg(OFF_PIN_DRIVE_LEVEL, v);
      settle();
      check("oe_n", port_oe_n, exp_oe_n(f, r));
      check("level", port_lvl, v);
      check("enable", led.enable, {~f, 8'hff});
    end
    host.write_reg(OFF_CHANNEL_FUNCTION, 8'hff);
    host.write_reg(OFF_PIN_DIRECTION, 8'hff);
    host.write_reg(OFF_CHANGE_ALERT_MASK, 8'h00);
    host.read_reg(OFF_PIN_INPUT_STATE, d);
    r = $random(seed) | 8'h80;
    @(posedge clk);
    pins <= r;
    repeat (8) @(negedge clk);
    check("alert set", alert_n, 1'b0);
    repeat (20) @(negedge clk);
    check("alert held", alert_n, 1'b0);
    host.read_reg(OFF_PIN_INPUT_STATE, d);
    check("state", d, r);
    check("alert clear", alert_n, 1'b1);
    host.read_reg(8'hc0, d);
    check("unmapped read", d, 8'h00);
    host.write_reg(OFF_CHANGE_ALERT_MASK, 8'hff);
    @(posedge clk);
    pins <= ~r;
    repeat (8) @(negedge clk);
    check("alert masked", alert_n, 1'b1);
    v = $random(seed);
    host.write_reg(OFF_FRAME_FIRST, {v[2:0], 5'h00});
    host.write_reg(OFF_CONFIG, 8'h20);
    settle();
    check("first frame", frame, v[2:0]);
    @(posedge clk);
    adc <= $random(seed);
    host.write_reg(OFF_SAMPLER_DIVISOR, 8'h02);
    host.write_reg(OFF_CONFIG, 8'h40);
    wait_strobe(gap);
    wait_strobe(gap);
    check("sample gap", 16'(gap), exp_gap(8'h02));
    settle();
    check("audio frame", frame, adc[7:5]);
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
endmodule
